// file: adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// Register byte offsets
`define OFS_ENABLES  8'h00
`define OFS_RAW      8'h04
`define OFS_MASK     8'h08
`define OFS_MSTAT    8'h0C
`define OFS_OVF      8'h10
`define OFS_TRGSEL   8'h14
`define OFS_UNF      8'h18
`define OFS_PRI      8'h20
`define OFS_SWTRIG   8'h28
// Per-sequencer window: addr[7:6]=01, addr[5:4]=sequencer, addr[3:2]=sub
`define SEQ_HI       2'h1
`define SUB_MUX      2'h0
`define SUB_CTL      2'h1
`define SUB_FIFO     2'h2
`define SUB_FSTAT    2'h3
// Control nibble bit positions
`define CTL_DIFF     0
`define CTL_END      1
`define CTL_IE       2
`define CTL_TEMP     3
// FIFO status field positions
`define FST_HEAD     4
`define FST_EMPTY    8
`define FST_FULL     12
// Reset priority value and priority write mask
`define RST_PRI      16'h3210
`define PRI_MASK     16'h3333
// Trigger source codes
`define SRC_PROC     4'h0
`define SRC_ALWAYS   4'hF
// Converter clock target and default source rate, in kHz
`define TARGET_KHZ   16667
`define SRC_KHZ_DEF  250000
`endif

// file: adc_seq_pkg.sv
package adc_seq_pkg;
    // Conversion engine states, Gray along idle-start-wait
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b11
    } seq_state_t;
    // One stored conversion result
    typedef logic [9:0] result_t;
    // FIFO pointer
    typedef logic [2:0] ptr_t;
endpackage

// file: adc_seq_ctrl.sv
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"
// Function
// [RULE1] Four sequencers: 8, 4, 4, 1 steps
// [RULE2] FIFO word holds result in low bits
// [RULE3] Step has input and control nibbles
// [RULE4] Triggers only accepted while sequencer enabled
// [RULE5] Software programs sequencer before enabling it
// [RULE6] Steps run back to back unattended
// [RULE7] Same input allowed in several steps
// [RULE8] Step interrupt enable raises raw interrupt
// [RULE9] First end flag stops the sequence
// [RULE10] Circular FIFO, read pops oldest entry
// [RULE11] Head, tail, full, empty readable
// [RULE12] Overflow and underflow flags per sequencer
// [RULE13] Converter clock divider set automatically
// [RULE14] Mask bit gates interrupt output
// [RULE15] Raw and masked status both readable
// [RULE16] Write one clears interrupt, zero ignored
// [RULE17] Lower priority value served first
// [RULE18] Software keeps priorities distinct
// [RULE19] Per-sequencer trigger source select
// [RULE20] Processor trigger register starts sequencer
// [RULE21] Software avoids high-priority always trigger
// [RULE22] Reset priorities: zero highest, three lowest
// [RULE23] Single-ended codes span full 10 bits
// [RULE24] Full FIFO drops, empty read flags
// [RULE25] Triggers while disabled are forgotten
module adc_seq_ctrl
    import adc_seq_pkg::*;
#(
    parameter int NUM_EXT = 4,
    parameter int SRC_KHZ = `SRC_KHZ_DEF
)(
    input  wire logic               mclk_in,
    input  wire logic               rst_b_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [31:0]        reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic      [31:0]        reg_rdata_out,
    input  wire logic [NUM_EXT-1:0] ext_trig_in,
    input  wire logic               conv_done_in,
    input  wire logic [9:0]         conv_result_in,
    output logic                    conv_start_out,
    output logic      [3:0]         conv_input_out,
    output logic                    conv_diff_out,
    output logic                    conv_temp_out,
    output logic      [3:0]         irq_out,
    output logic      [7:0]         adc_clk_div_out
);

    // Step count per sequencer, also the FIFO depth
    // [RULE1] Depths 8, 4, 4, 1
    function automatic logic [3:0] seq_steps(input logic [1:0] n);
        unique case (n)
            2'd0: seq_steps = 4'd8;
            2'd3: seq_steps = 4'd1;
            default: seq_steps = 4'd4;
        endcase
    endfunction

    // Writable nibble lanes of a sequencer's step registers
    function automatic logic [31:0] nib_mask(input logic [1:0] n);
        unique case (n)
            2'd0: nib_mask = 32'hFFFFFFFF;
            2'd3: nib_mask = 32'h0000000F;
            default: nib_mask = 32'h0000FFFF;
        endcase
    endfunction

    // Circular pointer advance, wraps at the depth
    function automatic ptr_t ptr_inc(input ptr_t p, input logic [1:0] n);
        ptr_inc = ({1'b0, p} + 4'd1 == seq_steps(n)) ? 3'd0 : p + 3'd1;
    endfunction

    // Divider ratio, rounded up so the converter never runs fast
    localparam int DIV = (SRC_KHZ + `TARGET_KHZ - 1) / `TARGET_KHZ;

    // Software-visible control
    logic [3:0]  en_ff;             // Sequencer enables
    logic [3:0]  mask_ff;           // Interrupt mask
    logic [15:0] emux_ff;           // Trigger source fields
    logic [15:0] pri_ff;            // Priority fields
    logic [31:0] mux_ff [4];        // Step input nibbles
    logic [31:0] ctl_ff [4];        // Step control nibbles
    // Status flags
    logic [3:0]  raw_ff;            // Raw interrupt status
    logic [3:0]  ovf_ff;            // FIFO overflow flags
    logic [3:0]  unf_ff;            // FIFO underflow flags
    logic [3:0]  irq_ff;            // Gated interrupt lines
    logic [31:0] rdata_ff;          // Read data, one cycle late
    // Trigger path
    logic [NUM_EXT-1:0] ext_s1_ff;  // Synchroniser first stage
    logic [NUM_EXT-1:0] ext_s2_ff;  // Synchroniser second stage
    logic [NUM_EXT-1:0] ext_s3_ff;  // Edge history
    logic [NUM_EXT-1:0] ext_rise;   // Rising edges
    logic [3:0]  sw_trig;           // Processor trigger pulses
    logic [3:0]  trig;              // Selected trigger per sequencer
    logic [3:0]  pend_ff;           // Accepted, not yet served
    logic [3:0]  grant;             // Sequencer chosen this cycle
    logic        win_vld;           // Some trigger pending
    logic [1:0]  win_idx;           // Winning sequencer
    // Engine
    seq_state_t  state_ff;          // Engine state
    logic [1:0]  cur_ff;            // Running sequencer
    ptr_t        step_ff;           // Running step
    logic [3:0]  cur_mux;           // Current step input nibble
    logic [3:0]  cur_ctl;           // Current step control nibble
    logic        last;              // Current step ends the sequence
    logic        push;              // Result arriving
    logic        step_done;         // Result taken in wait state
    logic        start_ff;          // Conversion start pulse
    logic [3:0]  sel_ff;            // Converter input select
    logic        diff_ff;           // Differential mode
    logic        temp_ff;           // Temperature sensor select
    logic [7:0]  div_ff;            // Converter clock divider
    // Result FIFOs
    result_t     mem_ff [4][8];     // Storage
    ptr_t        head_ff [4];       // Write pointers
    ptr_t        tail_ff [4];       // Read pointers
    logic [3:0]  cnt_ff [4];        // Fill counts
    logic [3:0]  full;              // Count at depth
    logic [3:0]  empty;             // Count at zero
    logic        is_seq;            // Address in sequencer window
    logic [1:0]  rsel;              // Addressed sequencer
    logic [1:0]  sub;               // Addressed sub-register
    logic        pop_req;           // Result port read
    logic [3:0]  ovf_set;           // Overflow events
    logic [3:0]  unf_set;           // Underflow events
    logic [3:0]  raw_set;           // Step interrupt events
    logic [3:0]  raw_clr;           // Software clears
    logic [31:0] fst;               // Status word for addressed FIFO

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // Address fields
    assign is_seq  = reg_addr_in[7:6] == `SEQ_HI;
    assign rsel    = reg_addr_in[5:4];
    assign sub     = reg_addr_in[3:2];
    assign pop_req = reg_rd_in && is_seq && sub == `SUB_FIFO;

    // Software-written control registers
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            en_ff   <= 4'h0;
            mask_ff <= 4'h0;
            emux_ff <= 16'h0000;
            // [RULE22] Default priority order
            pri_ff  <= `RST_PRI;
            for (int n = 0; n < 4; n++)
            begin
                mux_ff[n] <= 32'h00000000;
                ctl_ff[n] <= 32'h00000000;
            end
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `OFS_ENABLES)
                en_ff <= reg_wdata_in[3:0];
            if (reg_addr_in == `OFS_MASK)
                mask_ff <= reg_wdata_in[3:0];
            // [RULE19] Trigger source fields
            if (reg_addr_in == `OFS_TRGSEL)
                emux_ff <= reg_wdata_in[15:0];
            if (reg_addr_in == `OFS_PRI)
                pri_ff <= reg_wdata_in[15:0] & `PRI_MASK;
            // [RULE3] Nibbles beyond a sequencer's steps stay zero
            if (is_seq && sub == `SUB_MUX)
                mux_ff[rsel] <= reg_wdata_in & nib_mask(rsel);
            if (is_seq && sub == `SUB_CTL)
                ctl_ff[rsel] <= reg_wdata_in & nib_mask(rsel);
        end
    end

    // [RULE20] Processor trigger is a write-only pulse
    assign sw_trig = (reg_wr_in && reg_addr_in == `OFS_SWTRIG) ? reg_wdata_in[3:0] : 4'h0;

    // External triggers cross in through two flops, then edge detect
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            ext_s1_ff <= '0;
            ext_s2_ff <= '0;
            ext_s3_ff <= '0;
        end
        else
        begin
            ext_s1_ff <= ext_trig_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end
    assign ext_rise = ext_s2_ff & ~ext_s3_ff;

    // [RULE19] Per-sequencer source multiplexer
    always_comb
    begin
        logic [3:0] src;
        src  = 4'h0;
        trig = 4'h0;
        for (int n = 0; n < 4; n++)
        begin
            src = emux_ff[4*n +: 4];
            if (src == `SRC_PROC)
                trig[n] = sw_trig[n];
            else if (src == `SRC_ALWAYS)
                trig[n] = 1'b1;
            else if (int'(src) <= NUM_EXT)
                trig[n] = ext_rise[int'(src) - 1];
        end
    end

    // [RULE17] Lowest value wins; ties go to lower index
    always_comb
    begin
        win_vld = 1'b0;
        win_idx = 2'd0;
        for (int p = 3; p >= 0; p--)
        begin
            for (int s = 3; s >= 0; s--)
            begin
                if (pend_ff[s] && pri_ff[4*s +: 2] == 2'(p))
                begin
                    win_vld = 1'b1;
                    win_idx = 2'(s);
                end
            end
        end
    end
    assign grant = (state_ff == ST_IDLE && win_vld) ? (4'h1 << win_idx) : 4'h0;

    // Pending triggers; a new trigger while running is kept
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            pend_ff <= 4'h0;
        else
            // [RULE4] Only enabled sequencers accept triggers
            // [RULE25] Disabling drops anything held
            pend_ff <= (pend_ff | trig) & ~grant & en_ff;
    end

    // Current step decode
    assign cur_mux   = mux_ff[cur_ff][4*step_ff +: 4];
    assign cur_ctl   = ctl_ff[cur_ff][4*step_ff +: 4];
    // [RULE9] End flag or last slot closes the sequence
    assign last      = cur_ctl[`CTL_END] || ({1'b0, step_ff} + 4'd1 == seq_steps(cur_ff));
    assign step_done = state_ff == ST_WAIT && conv_done_in;
    assign push      = step_done;

    // Conversion engine; a done outside wait is ignored
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= ST_IDLE;
            cur_ff   <= 2'd0;
            step_ff  <= 3'd0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (win_vld)
                    begin
                        cur_ff   <= win_idx;
                        step_ff  <= 3'd0;
                        state_ff <= ST_START;
                    end
                end
                ST_START:
                    state_ff <= ST_WAIT;
                ST_WAIT:
                begin
                    if (conv_done_in)
                    begin
                        // [RULE6] Next step starts with no software help
                        if (last)
                            state_ff <= ST_IDLE;
                        else
                        begin
                            step_ff  <= step_ff + 3'd1;
                            state_ff <= ST_START;
                        end
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Converter controls, registered in the start state
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            start_ff <= 1'b0;
            sel_ff   <= 4'h0;
            diff_ff  <= 1'b0;
            temp_ff  <= 1'b0;
        end
        else
        begin
            start_ff <= state_ff == ST_START;
            if (state_ff == ST_START)
            begin
                // [RULE7] Any input in any step, repeats allowed
                sel_ff  <= cur_mux;
                diff_ff <= cur_ctl[`CTL_DIFF];
                temp_ff <= cur_ctl[`CTL_TEMP];
            end
        end
    end

    // [RULE13] Divider ratio fixed from the source clock rate
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            div_ff <= 8'(DIV);
        else
            div_ff <= 8'(DIV);
    end

    // FIFO flags
    always_comb
    begin
        for (int n = 0; n < 4; n++)
        begin
            full[n]  = cnt_ff[n] == seq_steps(2'(n));
            empty[n] = cnt_ff[n] == 4'd0;
        end
    end

    // [RULE10] Circular result FIFOs, head writes, tail pops
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            for (int n = 0; n < 4; n++)
            begin
                head_ff[n] <= 3'd0;
                tail_ff[n] <= 3'd0;
                cnt_ff[n]  <= 4'd0;
                for (int e = 0; e < 8; e++)
                    mem_ff[n][e] <= 10'h000;
            end
        end
        else
        begin
            for (int n = 0; n < 4; n++)
            begin
                logic wr_ok;
                logic rd_ok;
                // [RULE24] Full FIFO drops the result
                wr_ok = push && cur_ff == 2'(n) && !full[n];
                // [RULE24] Empty read leaves pointers alone
                rd_ok = pop_req && rsel == 2'(n) && !empty[n];
                if (wr_ok)
                begin
                    // [RULE23] Code stored as the converter gives it
                    mem_ff[n][head_ff[n]] <= conv_result_in;
                    head_ff[n] <= ptr_inc(head_ff[n], 2'(n));
                end
                if (rd_ok)
                    tail_ff[n] <= ptr_inc(tail_ff[n], 2'(n));
                cnt_ff[n] <= cnt_ff[n] + {3'd0, wr_ok} - {3'd0, rd_ok};
            end
        end
    end

    // Event and clear vectors
    assign ovf_set = (push && full[cur_ff]) ? (4'h1 << cur_ff) : 4'h0;
    assign unf_set = (pop_req && empty[rsel]) ? (4'h1 << rsel) : 4'h0;
    // [RULE8] Any step with its enable bit raises raw status
    assign raw_set = (step_done && cur_ctl[`CTL_IE]) ? (4'h1 << cur_ff) : 4'h0;
    // [RULE16] Ones clear, zeros leave bits alone
    assign raw_clr = (reg_wr_in && reg_addr_in == `OFS_MSTAT) ? reg_wdata_in[3:0] : 4'h0;

    // Sticky flags; a set in the clear cycle survives
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            raw_ff <= 4'h0;
            ovf_ff <= 4'h0;
            unf_ff <= 4'h0;
        end
        else
        begin
            raw_ff <= (raw_ff & ~raw_clr) | raw_set;
            // [RULE12] Overflow and underflow, cleared by writing one
            if (reg_wr_in && reg_addr_in == `OFS_OVF)
                ovf_ff <= (ovf_ff & ~reg_wdata_in[3:0]) | ovf_set;
            else
                ovf_ff <= ovf_ff | ovf_set;
            if (reg_wr_in && reg_addr_in == `OFS_UNF)
                unf_ff <= (unf_ff & ~reg_wdata_in[3:0]) | unf_set;
            else
                unf_ff <= unf_ff | unf_set;
        end
    end

    // [RULE14] Only unmasked sequencers reach the controller
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            irq_ff <= 4'h0;
        else
            irq_ff <= raw_ff & mask_ff;
    end

    // [RULE11] Pointer status word of the addressed FIFO
    always_comb
    begin
        fst = 32'h00000000;
        fst[2:0] = tail_ff[rsel];
        fst[`FST_HEAD +: 3] = head_ff[rsel];
        fst[`FST_EMPTY] = empty[rsel];
        fst[`FST_FULL] = full[rsel];
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            rdata_ff <= 32'h00000000;
        else if (!reg_rd_in)
            rdata_ff <= 32'h00000000;
        else if (is_seq)
        begin
            unique case (sub)
                `SUB_MUX:  rdata_ff <= mux_ff[rsel];
                `SUB_CTL:  rdata_ff <= ctl_ff[rsel];
                // [RULE2] Result zero-extended into a word
                `SUB_FIFO: rdata_ff <= empty[rsel] ? 32'h00000000 : {22'h000000, mem_ff[rsel][tail_ff[rsel]]};
                default:   rdata_ff <= fst;
            endcase
        end
        else
        begin
            unique case (reg_addr_in)
                `OFS_ENABLES: rdata_ff <= {28'h0000000, en_ff};
                // [RULE15] Raw and masked views
                `OFS_RAW:     rdata_ff <= {28'h0000000, raw_ff};
                `OFS_MASK:    rdata_ff <= {28'h0000000, mask_ff};
                `OFS_MSTAT:   rdata_ff <= {28'h0000000, raw_ff & mask_ff};
                `OFS_OVF:     rdata_ff <= {28'h0000000, ovf_ff};
                `OFS_TRGSEL:  rdata_ff <= {16'h0000, emux_ff};
                `OFS_UNF:     rdata_ff <= {28'h0000000, unf_ff};
                `OFS_PRI:     rdata_ff <= {16'h0000, pri_ff};
                default:      rdata_ff <= 32'h00000000;
            endcase
        end
    end

    // Outputs
    assign reg_rdata_out   = rdata_ff;
    assign conv_start_out  = start_ff;
    assign conv_input_out  = sel_ff;
    assign conv_diff_out   = diff_ff;
    assign conv_temp_out   = temp_ff;
    assign irq_out         = irq_ff;
    assign adc_clk_div_out = div_ff;

    // Checks
    property p_step_range;
        state_ff != ST_IDLE |-> {1'b0, step_ff} < seq_steps(cur_ff);
    endproperty
    a_step_range: assert property (p_step_range) else $error("step beyond slots"); // [RULE1]

    property p_fifo_depth;
        cnt_ff[0] <= 4'd8 && cnt_ff[1] <= 4'd4 && cnt_ff[2] <= 4'd4 && cnt_ff[3] <= 4'd1;
    endproperty
    a_fifo_depth: assert property (p_fifo_depth) else $error("fifo count over depth"); // [RULE1]

    property p_start_pulse;
        state_ff == ST_START |=> conv_start_out && state_ff == ST_WAIT ##1 !conv_start_out;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse wrong"); // [RULE6]

    property p_next_step;
        step_done && !last |=> state_ff == ST_START && step_ff == $past(step_ff) + 3'd1;
    endproperty
    a_next_step: assert property (p_next_step) else $error("no back to back step"); // [RULE6]

    property p_end_stop;
        step_done && last |=> state_ff == ST_IDLE;
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("sequence ran past end"); // [RULE9]

    property p_ie_raw;
        step_done && cur_ctl[`CTL_IE] |=> raw_ff[cur_ff];
    endproperty
    a_ie_raw: assert property (p_ie_raw) else $error("step interrupt lost"); // [RULE8]

    property p_mask_gate;
        ##1 (irq_out & ~$past(mask_ff)) == 4'h0;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked interrupt forwarded"); // [RULE14]

    property p_clear;
        raw_clr[0] && raw_set[0] == 1'b0 |=> !raw_ff[0] ##1 !irq_out[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed"); // [RULE16]

    property p_disabled;
        !en_ff[1] |=> !pend_ff[1];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled trigger kept"); // [RULE25]

    property p_priority;
        win_vld |-> !(pend_ff[0] && pri_ff[1:0] < pri_ff[4*win_idx +: 2])
            && !(pend_ff[3] && pri_ff[13:12] < pri_ff[4*win_idx +: 2]);
    endproperty
    a_priority: assert property (p_priority) else $error("lower priority won"); // [RULE17]

    property p_overflow;
        push && full[cur_ff] |=> ovf_ff[$past(cur_ff)]
            && cnt_ff[$past(cur_ff)] == $past(cnt_ff[cur_ff]) - {3'd0, $past(pop_req && rsel == cur_ff)};
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [RULE24]

    c_seq_done: cover property (step_done && last ##1 state_ff == ST_IDLE);
    c_overflow: cover property (push && full[cur_ff]);
    c_concurrent: cover property (state_ff == ST_IDLE && pend_ff[0] && pend_ff[3]);
    c_underflow: cover property (pop_req && empty[rsel]);

endmodule

// file: conv_model.sv
`timescale 1ns/100ps
// Converter core stand-in, quick or slow to answer
module conv_model
(
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic [3:0] input_in,
    input  wire logic       slow_in,
    output logic            done_out,
    output logic [9:0]      result_out
);
    logic [3:0] wait_ff; // Cycles left to answer
    logic [3:0] sel_ff;  // Input held from start
    // Code is input over a marker so the bench can predict it
    always_ff @(posedge mclk_in)
    begin
        done_out <= 1'b0;
        // Stale code flips, never left standing
        result_out <= ~result_out;
        if (!rst_b_in)
        begin
            wait_ff <= 4'h0;
            result_out <= 10'h2AA;
        end
        else if (start_in)
        begin
            sel_ff <= input_in;
            wait_ff <= slow_in ? 4'h9 : 4'h1;
        end
        else if (wait_ff != 4'h0)
        begin
            wait_ff <= wait_ff - 4'h1;
            if (wait_ff == 4'h1)
            begin
                done_out <= 1'b1;
                result_out <= {sel_ff, 6'h15};
            end
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        slow = 1'b0;  // Converter answers late
    logic [3:0]  first_in;     // Input of first start
    logic [3:0]  ext_trig = 4'h0; // External trigger lines
    wire  [31:0] reg_rdata_out;
    wire         done, start, diff, temp;
    wire  [9:0]  result;
    wire  [3:0]  sel, irq;
    wire  [7:0]  div;
    int          err_count = 0;
    int          tests_run = 0;
    int          starts = 0;
    int          cyc = 0;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} row_t;
    // Writes, or reads with expected data
    row_t rows[9] = '{'{0, 8'h20, 32'h3210}, '{0, 8'h4C, 32'h100}, '{0, 8'hFC, 0},
        '{1, 8'h40, 32'h11}, '{1, 8'h44, 32'h64}, '{0, 8'h44, 32'h64},
        '{1, 8'h08, 32'h1}, '{0, 8'h08, 32'h1}, '{1, 8'h28, 32'h1}};
    adc_seq_ctrl u_adc_seq_ctrl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .ext_trig_in(ext_trig), .conv_done_in(done),
        .conv_result_in(result), .conv_start_out(start), .conv_input_out(sel),
        .conv_diff_out(diff), .conv_temp_out(temp), .irq_out(irq), .adc_clk_div_out(div));
    conv_model u_conv_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .start_in(start),
        .input_in(sel), .slow_in(slow), .done_out(done), .result_out(result));
    always #2 mclk_in = ~mclk_in;
    // Count start pulses; timeout cuts a hang
    always @(posedge mclk_in)
    begin
        cyc++;
        if (start === 1'b1)
        begin
            if (starts == 0)
                first_in = sel;
            starts++;
        end
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        `CHK(reg_rdata_out, e)
    endtask
    task automatic stop_test();
        $display("errors %0d of %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(negedge mclk_in);
        `CHK(div, 8'((250000 + 16666) / 16667))
        `CHK(irq, 4'h0)
        foreach (rows[i])
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].d);
        repeat (20) @(posedge mclk_in);
        wr(8'h00, 32'h1);
        repeat (20) @(posedge mclk_in);
        `CHK(starts, 0)
        wr(8'h28, 32'h1);
        repeat (30) @(posedge mclk_in);
        `CHK(starts, 2)
        rd(8'h4C, 32'h20);
        rd(8'h48, 32'h055);
        rd(8'h48, 32'h055);
        rd(8'h48, 32'h0);
        rd(8'h18, 32'h1);
        rd(8'h04, 32'h1);
        `CHK(irq, 4'h1)
        wr(8'h0C, 32'h0);
        rd(8'h0C, 32'h1);
        wr(8'h0C, 32'h1);
        rd(8'h04, 32'h0);
        wr(8'h20, 32'h0213);
        wr(8'h70, 32'h5);
        wr(8'h74, 32'hB);
        wr(8'h00, 32'h9);
        starts = 0;
        slow <= 1'b1;
        wr(8'h28, 32'h9);
        repeat (80) @(posedge mclk_in);
        `CHK(first_in, 4'h5)
        `CHK(starts, 3)
        wr(8'h28, 32'h8);
        repeat (30) @(posedge mclk_in);
        rd(8'h10, 32'h8);
        rd(8'h78, 32'h155);
        `CHK(diff, 1'b1)
        `CHK(temp, 1'b1)
        // Always-on source kept at lowest priority
        wr(8'h00, 32'h0);
        wr(8'h20, 32'h1230);
        wr(8'h14, 32'h00F1);
        wr(8'h00, 32'h3);
        ext_trig <= 4'h1;
        repeat (200) @(posedge mclk_in);
        wr(8'h00, 32'h0);
        repeat (60) @(posedge mclk_in);
        rd(8'h4C, 32'h62);
        rd(8'h10, 32'hA);
        stop_test();
    end
endmodule
